// [src/cbr_top.sv]
// Configurable block RAM: register slave, port mapping and shift mode.
// Contract
// - All port inputs registered; each output may bypass its register.
// - Single-port mode uses one address: a read or a write.
// - Split mode gives two independent RAMs of half the storage each.
// - Single-port writes flow through; bypassed output shows new data.
// - Simple dual-port: one write on A, one read on B together.
// - Simple dual-port shapes mix freely within plain or parity group.
// - One write gate, one read gate; read gate resets high.
// - Read gate low keeps the last read data on the outputs; shift mode reads on ce and we alone.
// - Mixed read of a word being written: unknown or old data.
// - True dual-port: each port reads or writes independently; when both write one row, only B's write lands.
// - True dual-port widest shape is 256 by 16 or 18.
// - True dual-port shapes mix freely within one group only.
// - True dual-port writes flow through to the same port output.
// - Write captured on a rising edge, committed on the next rising edge.
// - Shift register: w*m*n at most 4608, w*n at most 36.
// - Shift mode reads then writes each location, one step a cycle.
// - Outputs read zero after reset whatever the memory holds.
// - Masked byte lanes keep old contents; lane mask resets high.
`timescale 1ns/1ps
`default_nettype none
`include "cbr_defines.svh"
module cbr_top
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`CBR_AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`CBR_AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cbr_pkg::cbr_port_t port_a,
   output logic [`CBR_ROW_W-1:0] q_a,
   input wire cbr_pkg::cbr_port_t port_b,
   output logic [`CBR_ROW_W-1:0] q_b
);
   import cbr_pkg::*;

   cbr_state_t s;
   cbr_state_t n;
   cbr_req_t ma;
   cbr_req_t mb;
   cbr_map_t map_a;
   cbr_map_t map_b;
   cbr_mode_t mode;
   cbr_shape_t sh_a;
   cbr_shape_t sh_b;
   logic [`CBR_ROW_W-1:0] rd_a;
   logic [`CBR_ROW_W-1:0] rd_b;
   logic [`CBR_ROW_W-1:0] sl_a;
   logic [`CBR_ROW_W-1:0] sl_b;
   logic [`CBR_ROW_W-1:0] nmask;
   logic [5:0] tap_w;
   logic [7:0] tap_m;
   logic [5:0] tap_n;
   logic [11:0] tap_bits;
   logic [19:0] tot_bits;
   logic cfg_ok;
   logic shift_on;
   logic a_rd;
   logic a_wr;
   logic b_rd;
   logic b_wr;
   logic [`CBR_ROW_AW-1:0] row_a;
   logic [`CBR_ROW_AW-1:0] row_b;
   logic [31:0] strb_m;
   logic [31:0] stat;
   logic [31:0] rd_val;

   // --------
   // Shape helpers
   // --------
   // Log2 of the word width in units of one bit or one parity byte
   function automatic logic [2:0] lk_of(input cbr_shape_t sh);
      case (sh)
         CBR_S2, CBR_S18: lk_of = 3'h1;
         CBR_S4, CBR_S36: lk_of = 3'h2;
         CBR_S8: lk_of = 3'h3;
         CBR_S16: lk_of = 3'h4;
         CBR_S32: lk_of = 3'h5;
         default: lk_of = 3'h0;
      endcase
   endfunction

   function automatic logic par_of(input cbr_shape_t sh);
      return sh >= CBR_S9;
   endfunction

   function automatic logic [5:0] width_of(input cbr_shape_t sh);
      return par_of(sh) ? 6'(6'h9 << lk_of(sh)) : 6'(6'h1 << lk_of(sh));
   endfunction

   // Plain shapes pack into 32 bits of a row, parity shapes into all 36;
   // lower narrow addresses take the lower bits of the row
   function automatic cbr_map_t map_addr(input cbr_shape_t sh,
      input logic [`CBR_ADDR_W-1:0] addr);
      cbr_map_t m;
      logic [2:0] rs;
      logic [`CBR_ADDR_W-1:0] slot;
      logic [5:0] sl;
      rs = (par_of(sh) ? 3'h2 : 3'h5) - lk_of(sh);
      slot = addr & ((12'h1 << rs) - 12'h1);
      sl = 6'(slot << lk_of(sh));
      m.row = 7'(addr >> rs);
      m.off = par_of(sh) ? 6'(sl * 6'h9) : sl;
      m.mask = 36'((37'h1 << width_of(sh)) - 37'h1);
      return m;
   endfunction

   // Lanes are 8 bits, or 9 with parity; narrow words ignore the mask
   function automatic logic [`CBR_ROW_W-1:0] lane_mask(
      input cbr_shape_t sh,
      input logic [`CBR_LANES-1:0] be);
      logic [`CBR_ROW_W-1:0] m;
      logic wide;
      int lane;
      m = '1;
      wide = par_of(sh) ? (lk_of(sh) >= 3'h1) : (lk_of(sh) >= 3'h4);
      for (int i = 0; i < `CBR_ROW_W; i++)
      begin
         lane = par_of(sh) ? i / 9 : i / 8;
         if (wide && lane < `CBR_LANES && !be[2'(lane)])
         begin
            m[i] = 1'b0;
         end
      end
      return m;
   endfunction

   // --------
   // Configuration decode and checks
   // --------
   assign mode = cbr_mode_t'(s.ctrl[`CBR_CTRL_MODE +: 3]);
   assign sh_a = cbr_shape_t'(s.shape[`CBR_SHAPE_A +: 4]);
   assign sh_b = cbr_shape_t'(s.shape[`CBR_SHAPE_B +: 4]);
   assign tap_w = width_of(sh_a);
   assign tap_m = s.shift[`CBR_SHIFT_LEN +: 8];
   assign tap_n = s.shift[`CBR_SHIFT_CNT +: 6];
   assign tap_bits = 12'(tap_w) * 12'(tap_n);
   assign tot_bits = 20'(tap_bits) * 20'(tap_m);
   assign nmask = 36'((37'h1 << tap_bits) - 37'h1);
   assign shift_on = cfg_ok && mode == CBR_SHIFT;
   assign map_a = map_addr(sh_a, s.ia.addr);
   assign map_b = map_addr(sh_b, s.ib.addr);

   // Illegal settings stop both ports instead of corrupting storage
   always_comb
   begin
      cfg_ok = 1'b1;
      if (mode > CBR_SHIFT || sh_a > CBR_S36 || sh_b > CBR_S36)
      begin
         cfg_ok = 1'b0;
      end
      if ((mode == CBR_SDP || mode == CBR_TDP)
         && par_of(sh_a) != par_of(sh_b))
      begin
         cfg_ok = 1'b0;
      end
      if (mode == CBR_TDP && (sh_a == CBR_S32 || sh_a == CBR_S36
         || sh_b == CBR_S32 || sh_b == CBR_S36))
      begin
         cfg_ok = 1'b0;
      end
      if (mode == CBR_SHIFT && (tap_n == 6'h0
         || tap_m < `CBR_MIN_TAP_LEN || tap_m > `CBR_ROWS
         || tap_bits > `CBR_MAX_TAP_BITS
         || tot_bits > `CBR_TOTAL_BITS))
      begin
         cfg_ok = 1'b0;
      end
      // Port roles per mode; single port leaves B idle
      a_rd = cfg_ok && (mode == CBR_SP || mode == CBR_SP2
         || mode == CBR_TDP);
      a_wr = cfg_ok && mode != CBR_SHIFT;
      b_rd = cfg_ok && (mode == CBR_SP2 || mode == CBR_SDP
         || mode == CBR_TDP);
      b_wr = cfg_ok && (mode == CBR_SP2 || mode == CBR_TDP);
   end

   // Split mode pins each port into its own half of the rows
   assign row_a = mode == CBR_SP2 ? {1'b0, map_a.row[5:0]} : map_a.row;
   assign row_b = mode == CBR_SP2 ? {1'b1, map_b.row[5:0]} : map_b.row;

   // --------
   // Memory requests from the input registers
   // --------
   always_comb
   begin
      ma = '0;
      mb = '0;
      if (shift_on)
      begin
         // Read the oldest row now, write it back shifted next cycle
         ma.re = s.ia.ce && s.ia.we;
         ma.row = s.ptr;
         mb.we = s.sh_v;
         mb.row = s.sh_row;
         mb.wdata = ((rd_a << tap_w) | s.sh_din) & nmask;
         mb.wmask = nmask;
      end
      else
      begin
         ma.we = a_wr && s.ia.ce && s.ia.we;
         ma.re = a_rd && s.ia.ce && s.ia.rden;
         ma.row = row_a;
         ma.wdata = s.ia.data << map_a.off;
         ma.wmask = (map_a.mask & lane_mask(sh_a, s.ia.be))
            << map_a.off;
         mb.we = b_wr && s.ib.ce && s.ib.we;
         mb.re = b_rd && s.ib.ce && s.ib.rden;
         mb.row = row_b;
         mb.wdata = s.ib.data << map_b.off;
         mb.wmask = (map_b.mask & lane_mask(sh_b, s.ib.be))
            << map_b.off;
      end
   end

   cbr_mem #(
      .ROWS(`CBR_ROWS),
      .AW(`CBR_ROW_AW),
      .W(`CBR_ROW_W)
   ) u_mem (
      .aclk(aclk),
      .a_we(ma.we),
      .a_re(ma.re),
      .a_row(ma.row),
      .a_wdata(ma.wdata),
      .a_wmask(ma.wmask),
      .a_rdata(rd_a),
      .b_we(mb.we),
      .b_re(mb.re),
      .b_row(mb.row),
      .b_wdata(mb.wdata),
      .b_wmask(mb.wmask),
      .b_rdata(rd_b)
   );

   // Read slices; a mixed-port hit reads unknown unless old data chosen
   assign sl_a = (s.sa.coll && !s.ctrl[`CBR_CTRL_RDW_OLD]) ?
      (`CBR_UNK_DATA & s.sa.mask) : ((rd_a >> s.sa.off) & s.sa.mask);
   assign sl_b = (s.sb.coll && !s.ctrl[`CBR_CTRL_RDW_OLD]) ?
      (`CBR_UNK_DATA & s.sb.mask) : ((rd_b >> s.sb.off) & s.sb.mask);

   // --------
   // Register read mux
   // --------
   assign stat = (32'(!cfg_ok) << `CBR_STAT_ERR)
      | (32'(s.ptr) << `CBR_STAT_PTR);

   always_comb
   begin
      case (s_axi_araddr)
         `CBR_REG_CTRL: rd_val = s.ctrl;
         `CBR_REG_SHAPE: rd_val = s.shape;
         `CBR_REG_SHIFT: rd_val = s.shift;
         `CBR_REG_STATUS: rd_val = stat;
         default: rd_val = '0;
      endcase
      for (int i = 0; i < 4; i++)
      begin
         strb_m[8*i +: 8] = {8{s.wstrb[i]}};
      end
   end

   // --------
   // Next state
   // --------
   always_comb
   begin
      n = s;
      // Input registers sample every cycle; ce qualifies the use
      n.ia = port_a;
      n.ib = port_b;
      n.sa.v = ma.re;
      n.sa.off = shift_on ? 6'h0 : map_a.off;
      n.sa.mask = shift_on ? nmask : map_a.mask;
      n.sa.coll = !shift_on && ma.re && mb.we && ma.row == mb.row
         && |(mb.wmask & (map_a.mask << map_a.off));
      n.sb.v = mb.re;
      n.sb.off = map_b.off;
      n.sb.mask = map_b.mask;
      n.sb.coll = mb.re && ma.we && ma.row == mb.row
         && |(ma.wmask & (map_b.mask << map_b.off));
      // Shift pointer walks a ring of tap_m rows
      n.sh_v = shift_on && ma.re;
      n.sh_row = s.ptr;
      n.sh_din = s.ia.data & map_a.mask;
      if (!shift_on)
      begin
         n.ptr = '0;
      end
      else if (ma.re)
      begin
         n.ptr = (8'(s.ptr) >= tap_m - 8'h1) ? '0 : s.ptr + 7'h1;
      end
      // Pipe register holds on a closed read gate outside shift mode; flow-through comes
      // from the memory's write-first read
      if (s.sa.v)
      begin
         n.pa = sl_a;
      end
      if (s.sb.v)
      begin
         n.pb = sl_b;
      end
      n.qa = s.ctrl[`CBR_CTRL_OREG_A] ? s.pa : n.pa;
      n.qb = s.ctrl[`CBR_CTRL_OREG_B] ? s.pb : n.pb;
      // AXI4-Lite write: address and data in either order
      if (s_axi_awvalid && s.awrdy)
      begin
         n.aw_got = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wrdy)
      begin
         n.w_got = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (s.aw_got && s.w_got && !s.bvalid)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `CBR_RESP_OKAY;
         case (s.awaddr)
            `CBR_REG_CTRL: n.ctrl = ((s.ctrl & ~strb_m)
               | (s.wdata & strb_m)) & `CBR_CTRL_MASK;
            `CBR_REG_SHAPE: n.shape = ((s.shape & ~strb_m)
               | (s.wdata & strb_m)) & `CBR_SHAPE_MASK;
            `CBR_REG_SHIFT: n.shift = ((s.shift & ~strb_m)
               | (s.wdata & strb_m)) & `CBR_SHIFT_MASK;
            `CBR_REG_STATUS: n.bresp = `CBR_RESP_OKAY;
            default: n.bresp = `CBR_RESP_SLVERR;
         endcase
      end
      if (s.bvalid && s_axi_bready)
      begin
         n.bvalid = 1'b0;
      end
      // AXI4-Lite read: answered at the edge that takes the address
      if (s_axi_arvalid && s.arrdy)
      begin
         n.rvalid = 1'b1;
         n.rdata = rd_val;
         n.rresp = (s_axi_araddr == `CBR_REG_CTRL
            || s_axi_araddr == `CBR_REG_SHAPE
            || s_axi_araddr == `CBR_REG_SHIFT
            || s_axi_araddr == `CBR_REG_STATUS) ?
            `CBR_RESP_OKAY : `CBR_RESP_SLVERR;
      end
      else if (s.rvalid && s_axi_rready)
      begin
         n.rvalid = 1'b0;
      end
      n.awrdy = !n.aw_got && !n.bvalid;
      n.wrdy = !n.w_got && !n.bvalid;
      n.arrdy = !n.rvalid;
      // Synchronous reset; read gates and lane masks clear to high
      if (!aresetn)
      begin
         n = '0;
         n.ctrl = `CBR_CTRL_RST;
         n.shape = `CBR_SHAPE_RST;
         n.shift = `CBR_SHIFT_RST;
         n.ia.rden = 1'b1;
         n.ib.rden = 1'b1;
         n.ia.be = `CBR_BE_RST;
         n.ib.be = `CBR_BE_RST;
      end
   end

   // Outputs reset to zero regardless of memory contents
   always_ff @(posedge aclk)
   begin
      s <= n;
   end

   assign s_axi_awready = s.awrdy;
   assign s_axi_wready = s.wrdy;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arrdy;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign q_a = s.qa;
   assign q_b = s.qb;
endmodule
`default_nettype wire

// [pkg/cbr_defines.svh]
// Constants of the configurable block RAM: geometry, register map, resets.
`ifndef CBR_DEFINES_SVH
`define CBR_DEFINES_SVH

// --------
// Storage geometry
// --------
`define CBR_ROWS 128
`define CBR_ROW_AW 7
`define CBR_ROW_W 36
`define CBR_ADDR_W 12
`define CBR_LANES 4
`define CBR_TOTAL_BITS 4608
`define CBR_MAX_TAP_BITS 36
`define CBR_MIN_TAP_LEN 2

// --------
// Register map, byte addresses
// --------
`define CBR_AXI_AW 8
`define CBR_REG_CTRL 8'h00
`define CBR_REG_SHAPE 8'h04
`define CBR_REG_SHIFT 8'h08
`define CBR_REG_STATUS 8'h0C

// --------
// Field positions and implemented bits
// --------
`define CBR_CTRL_MODE 0
`define CBR_CTRL_OREG_A 4
`define CBR_CTRL_OREG_B 5
`define CBR_CTRL_RDW_OLD 6
`define CBR_SHAPE_A 4'h0
`define CBR_SHAPE_B 4'h4
`define CBR_SHIFT_LEN 0
`define CBR_SHIFT_CNT 8
`define CBR_STAT_ERR 0
`define CBR_STAT_PTR 8
`define CBR_CTRL_MASK 32'h0000_0077
`define CBR_SHAPE_MASK 32'h0000_00FF
`define CBR_SHIFT_MASK 32'h0000_3FFF

// --------
// Reset values and answers
// --------
`define CBR_CTRL_RST 32'h0000_0030
`define CBR_SHAPE_RST 32'h0000_0000
`define CBR_SHIFT_RST 32'h0000_0102
`define CBR_BE_RST 4'hF
`define CBR_UNK_DATA 36'hF_FFFF_FFFF
`define CBR_RESP_OKAY 2'h0
`define CBR_RESP_SLVERR 2'h2

`endif

// [pkg/cbr_pkg.sv]
// Types shared by the configurable block RAM files.
`include "cbr_defines.svh"
package cbr_pkg;
   typedef enum logic [2:0] {CBR_SP, CBR_SP2, CBR_SDP, CBR_TDP,
      CBR_SHIFT} cbr_mode_t;
   typedef enum logic [3:0] {CBR_S1, CBR_S2, CBR_S4, CBR_S8, CBR_S16,
      CBR_S32, CBR_S9, CBR_S18, CBR_S36} cbr_shape_t;
   // One user port: clock enable, write, read gate, lanes, address, data
   typedef struct packed {
      logic ce;
      logic we;
      logic rden;
      logic [`CBR_LANES-1:0] be;
      logic [`CBR_ADDR_W-1:0] addr;
      logic [`CBR_ROW_W-1:0] data;
   } cbr_port_t;
   typedef struct packed {
      logic [`CBR_ROW_AW-1:0] row;
      logic [5:0] off;
      logic [`CBR_ROW_W-1:0] mask;
   } cbr_map_t;
   typedef struct packed {
      logic we;
      logic re;
      logic [`CBR_ROW_AW-1:0] row;
      logic [`CBR_ROW_W-1:0] wdata;
      logic [`CBR_ROW_W-1:0] wmask;
   } cbr_req_t;
   // Read in flight, aligned with the memory read register
   typedef struct packed {
      logic v;
      logic coll;
      logic [5:0] off;
      logic [`CBR_ROW_W-1:0] mask;
   } cbr_stage_t;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] shape;
      logic [31:0] shift;
      logic awrdy;
      logic wrdy;
      logic aw_got;
      logic w_got;
      logic [`CBR_AXI_AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arrdy;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      cbr_port_t ia;
      cbr_port_t ib;
      cbr_stage_t sa;
      cbr_stage_t sb;
      logic [`CBR_ROW_AW-1:0] ptr;
      logic sh_v;
      logic [`CBR_ROW_AW-1:0] sh_row;
      logic [`CBR_ROW_W-1:0] sh_din;
      logic [`CBR_ROW_W-1:0] pa;
      logic [`CBR_ROW_W-1:0] pb;
      logic [`CBR_ROW_W-1:0] qa;
      logic [`CBR_ROW_W-1:0] qb;
   } cbr_state_t;
endpackage

// [src/cbr_mem.sv]
// Two-port row memory with bit-masked writes and registered read data.
`timescale 1ns/1ps
`default_nettype none
module cbr_mem
#(
   parameter int ROWS = 128,
   parameter int AW = 7,
   parameter int W = 36
)
(
   input wire logic aclk,
   input wire logic a_we,
   input wire logic a_re,
   input wire logic [AW-1:0] a_row,
   input wire logic [W-1:0] a_wdata,
   input wire logic [W-1:0] a_wmask,
   output logic [W-1:0] a_rdata,
   input wire logic b_we,
   input wire logic b_re,
   input wire logic [AW-1:0] b_row,
   input wire logic [W-1:0] b_wdata,
   input wire logic [W-1:0] b_wmask,
   output logic [W-1:0] b_rdata
);
   logic [W-1:0] arr [ROWS];

   // --------
   // Array and read registers
   // --------
   // A port sees its own write at once (flow-through); the other port
   // reads the row as it stood before the edge, i.e. old data.
   always_ff @(posedge aclk)
   begin
      if (a_we)
      begin
         arr[a_row] <= (arr[a_row] & ~a_wmask) | (a_wdata & a_wmask);
      end
      if (b_we)
      begin
         arr[b_row] <= (arr[b_row] & ~b_wmask) | (b_wdata & b_wmask);
      end
      if (a_re)
      begin
         a_rdata <= a_we ? ((arr[a_row] & ~a_wmask) | (a_wdata & a_wmask))
            : arr[a_row];
      end
      if (b_re)
      begin
         b_rdata <= b_we ? ((arr[b_row] & ~b_wmask) | (b_wdata & b_wmask))
            : arr[b_row];
      end
   end
endmodule
`default_nettype wire

// [verification/cbr_checker.sv]
// Bus and port timing checks for the configurable block RAM.
`timescale 1ns/1ps
`default_nettype none
`include "cbr_defines.svh"
module cbr_checker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cbr_pkg::cbr_port_t port_a,
   input wire logic [`CBR_ROW_W-1:0] q_a,
   input wire cbr_pkg::cbr_port_t port_b,
   input wire logic [`CBR_ROW_W-1:0] q_b
);
   import cbr_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // --------
   // Sequences
   // --------
   // Four idle edges drain the whole port pipeline
   sequence s_quiet_a;
      !port_a.ce [*4];
   endsequence
   sequence s_quiet_b;
      !port_b.ce [*4];
   endsequence
   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // --------
   // Assertions
   // --------
   a_reset_clears: assert property (disable iff (1'b0)
      !aresetn |=> q_a == '0 && q_b == '0 && !s_axi_bvalid && !s_axi_rvalid)
      else $error("outputs not cleared by reset");
   a_hold_qa: assert property (s_quiet_a |=> $stable(q_a))
      else $error("q_a moved without a request");
   a_hold_qb: assert property (s_quiet_b |=> $stable(q_b))
      else $error("q_b moved without a request");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_read_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   a_resp_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_write_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_write_block: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
endmodule
`default_nettype wire

// [verification/cbr_user_model.sv]
// Model of the user logic that drives both RAM ports.
`timescale 1ns/1ps
`default_nettype none
module cbr_user_model
(
   input wire logic aclk,
   output cbr_pkg::cbr_port_t port_a,
   output cbr_pkg::cbr_port_t port_b
);
   import cbr_pkg::*;
   // Idle ports keep read gate and lane mask at their reset level
   initial
   begin
      port_a = '{ce: 1'b0, we: 1'b0, rden: 1'b1, be: 4'hF, default: '0};
      port_b = port_a;
   end
   // One request per port; the caller says whether ce drops after it
   task automatic step(input cbr_port_t a, input cbr_port_t b,
      input logic last);
      cbr_port_t c;
      begin
         c = b;
         // Same word from both ports is never written together
         if (a.ce && a.we && c.we && a.addr == c.addr)
            c.ce = 1'b0;
         port_a <= a;
         port_b <= c;
         @(posedge aclk);
         // Idle data lines wander so stale values cannot pass
         if (last)
         begin
            port_a <= '{ce: 1'b0, rden: 1'b1, be: 4'hF, data: ~a.data,
               default: '0};
            port_b <= '{ce: 1'b0, rden: 1'b1, be: 4'hF, data: ~c.data,
               default: '0};
         end
      end
   endtask
endmodule
`default_nettype wire

// [verification/test_cbr_top.sv]
// Self-checking bench for the configurable block RAM.
`timescale 1ns/1ps
`default_nettype none
`include "cbr_defines.svh"
module test_cbr_top;
   import cbr_pkg::*;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h1527, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [35:0] q_a, q_b;
   cbr_port_t port_a, port_b;
   cbr_port_t z = '{ce: 1'b0, rden: 1'b1, be: 4'hF, default: '0};
   logic [31:0] m [128];
   logic [31:0] v [10];
   logic [31:0] bad [5][4] = '{'{32'h3, 32'h55, 32'h102, 32'h1},
      '{32'h3, 32'h64, 32'h102, 32'h1}, '{32'h2, 32'h65, 32'h102, 32'h1},
      '{32'h4, 32'h3, 32'h503, 32'h1}, '{32'h2, 32'h35, 32'h102, 32'h0}};
   int fail_count = 0, samples_checked = 0;
   cbr_top i_cbr_top (.*);
   cbr_user_model i_cbr_user_model (.*);
   initial forever #25 aclk = ~aclk;
   // --------
   // Helpers
   // --------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic cbr_port_t mk(logic w, int a, logic [35:0] x,
      logic [3:0] be);
      return '{1'b1, w, 1'b1, be, a[11:0], x};
   endfunction
   // Reference store: plain shapes pack 32 bits a row, low address first
   function automatic logic [31:0] mrd(int w, int a);
      return 32'((m[a * w / 32] >> (a * w % 32)) & ((64'h1 << w) - 1));
   endfunction
   task automatic mwr(int w, int a, logic [31:0] x, logic [3:0] be);
      logic [31:0] k;
      begin
         k = 32'((64'h1 << w) - 1);
         for (int i = 0; i < 4; i++)
            if (w > 8 && !be[i]) k[8*i +: 8] = 8'h00;
         k = k << (a * w % 32);
         m[a * w / 32] = (m[a * w / 32] & ~k) | ((x << (a * w % 32)) & k);
      end
   endtask
   task automatic chk(input logic [71:0] s, input logic [71:0] e);
      samples_checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic conclude;
      if (fail_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Ready lines rise at random and stay up until the answer
   task automatic axw(input logic [7:0] a, input logic [31:0] x);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= x;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= ^xs();
      forever
      begin
         @(posedge aclk);
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         s_axi_bready <= s_axi_bready | ^xs();
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= ^xs();
      forever
      begin
         @(posedge aclk);
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         s_axi_rready <= s_axi_rready | ^xs();
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic cfg(input logic [31:0] c, s, h);
      axw(`CBR_REG_CTRL, c);
      axw(`CBR_REG_SHAPE, s);
      axw(`CBR_REG_SHIFT, h);
   endtask
   // Bypassed output settles two edges after the sampling edge
   task automatic op(input cbr_port_t a, input cbr_port_t b);
      @(posedge aclk);
      i_cbr_user_model.step(a, b, 1'b1);
      repeat (2) @(posedge aclk);
      #1;
   endtask
   // --------
   // Scenarios
   // --------
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      #1 chk({q_a, q_b}, 72'h0);
      axr(`CBR_REG_CTRL);
      chk(d, `CBR_CTRL_RST);
      axr(8'h10);
      chk({r, d}, {`CBR_RESP_SLVERR, 32'h0});
      // Shapes outside one group, too wide, or too large a shift; last a legal plain mix
      foreach (bad[i])
      begin
         cfg(bad[i][0], bad[i][1], bad[i][2]);
         axr(`CBR_REG_STATUS);
         chk(d[0], bad[i][3]);
      end
      // Single port: flow-through writes, masked lanes, read back
      cfg(32'h0, 32'h5, `CBR_SHIFT_RST);
      for (int i = 0; i < 4; i++)
      begin
         d = xs();
         mwr(32, i, d, 4'hF);
         op(mk(1'b1, i, d, 4'hF), z);
         chk(q_a, d);
         d = xs();
         mwr(32, i, d, 4'h5);
         op(mk(1'b1, i, d, 4'h5), z);
         chk(q_a, m[i]);
      end
      axw(`CBR_REG_CTRL, 32'h10);
      op(mk(1'b0, 1, 0, 4'hF), z);
      @(posedge aclk);
      op(mk(1'b0, 0, 0, 4'hF), z);
      chk(q_a, m[1]);
      @(posedge aclk);
      #1 chk(q_a, m[0]);
      // Simple dual-port: read during write of one word, mixed widths
      cfg(32'h42, 32'h35, `CBR_SHIFT_RST);
      v[0] = mrd(8, 8);
      d = xs();
      mwr(32, 2, d, 4'hF);
      op(mk(1'b1, 2, d, 4'hF), mk(1'b0, 8, 0, 4'hF));
      chk(q_b, v[0]);
      axw(`CBR_REG_CTRL, 32'h2);
      op(mk(1'b1, 2, xs(), 4'hF), mk(1'b0, 9, 0, 4'hF));
      chk(q_b, 36'hFF);
      mwr(32, 2, i_cbr_user_model.port_a.data[31:0] ^ 32'hFFFFFFFF, 4'hF);
      for (int i = 0; i < 4; i++)
      begin
         op(z, mk(1'b0, 8 + i, 0, 4'hF));
         chk(q_b, mrd(8, 8 + i));
      end
      op(z, '{1'b1, 1'b0, 1'b0, 4'hF, 12'h8, 36'h0});
      chk(q_b, mrd(8, 11));
      // True dual-port: both ports write, then read across
      cfg(32'h3, 32'h44, `CBR_SHIFT_RST);
      v[1] = xs();
      v[2] = xs();
      mwr(16, 6, v[1], 4'hF);
      mwr(16, 9, v[2], 4'hF);
      op(mk(1'b1, 6, v[1], 4'hF), mk(1'b1, 9, v[2], 4'hF));
      chk({q_a, q_b}, {4'h0, mrd(16, 6), 4'h0, mrd(16, 9)});
      op(mk(1'b0, 9, 0, 4'hF), mk(1'b0, 6, 0, 4'hF));
      chk({q_a, q_b}, {4'h0, mrd(16, 9), 4'h0, mrd(16, 6)});
      // Split: each half keeps its own word at address 0
      cfg(32'h1, 32'h55, `CBR_SHIFT_RST);
      v[3] = xs();
      v[4] = xs();
      op(mk(1'b1, 0, v[3], 4'hF), z);
      op(z, mk(1'b1, 0, v[4], 4'hF));
      op(mk(1'b0, 0, 0, 4'hF), mk(1'b0, 0, 0, 4'hF));
      chk({q_a, q_b}, {4'h0, v[3], 4'h0, v[4]});
      // Shift register: 8 bits wide, taps 3 apart, two taps
      cfg(32'h4, 32'h3, 32'h203);
      for (int i = 0; i < 10; i++)
      begin
         v[i] = xs();
         i_cbr_user_model.step(mk(1'b1, 0, v[i], 4'hF), z, i == 9);
      end
      repeat (2) @(posedge aclk);
      #1 chk(q_a, {v[3][7:0], v[6][7:0]});
      conclude;
   end
   // A hang ends the run as a failure
   initial
   begin
      repeat (8000) @(posedge aclk);
      fail_count++;
      conclude;
   end
endmodule
bind cbr_top cbr_checker i_cbr_checker (.*);
`default_nettype wire
